// ==== src/word_unit_regs.svh ====
`ifndef WORD_UNIT_REGS_SVH
`define WORD_UNIT_REGS_SVH

// ************************************************************
// limits of the count operand
// ************************************************************
`define AVG_N_MAX 7'h40
`define HEX_N_MAX 7'h20

// ************************************************************
// filter constant scaling and clamp
// ************************************************************
`define FRAC_LIMIT 16'h270F
`define FRAC_SCALE 32'h0000_2710

// ************************************************************
// ascii digit encoding
// ************************************************************
`define ASCII_DIGIT_BASE 8'h30
`define ASCII_ALPHA_BASE 8'h41
`define HEX_DIGIT_TEN 4'hA

// ************************************************************
// reset values
// ************************************************************
`define WORD_RST 16'h0000
`define SUM_RST 22'h00_0000
`define PTR_RST 6'h00
`define COUNT_RST 7'h00

`endif

// ==== src/word_unit_pkg.sv ====
package word_unit_pkg;

  // ************************************************************
  // operation select
  // ************************************************************
  typedef enum logic [2:0] {
    or_op,
    xor_op,
    moving_average_op,
    recursive_filter_op,
    hex_to_ascii_op
  } op_t;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    st_idle,
    st_avg,
    st_filter,
    st_hex_lo,
    st_hex_hi
  } state_t;

endpackage

// ==== src/history_mem.sv ====
`timescale 1ns/100ps

// one write port, one read port, read data registered
module history_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [WIDTH-1:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ==== src/word_logic_filter_hexascii_unit.sv ====
`timescale 1ns/100ps
`include "word_unit_regs.svh"

// Functional notes
// - or of two sources into destination
// - exclusive or of two sources into destination
// - rung low, count out of range or unknown op skips work and drops output
// - moving average over latest n, 1..64
// - n-word history table, pointer in next word
// - output is (1-fraction)x plus fraction times previous
// - fraction is constant operand over 10000
// - clamp filter constant into 0..9999
// - word after destination holds filter residue
// - n source words to ascii, 1..32
// - top nibble first, low byte then high
// - digits 30h..39h, letters 41h..46h
// - each source word gives two destination words
module word_logic_filter_hexascii_unit #(
  parameter int HIST_DEPTH = 64
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // command
  input wire logic start,
  input wire word_unit_pkg::op_t op_sel,
  input wire logic rung_in,
  input wire logic [15:0] src_a,
  input wire logic [15:0] src_b,
  input wire logic [6:0] count_n,
  // hex source fetch
  output logic [4:0] src_index,
  // results
  output logic busy,
  output logic done,
  output logic rung_out,
  output logic dest_valid,
  output logic [5:0] dest_index,
  output logic [15:0] dest_word,
  output logic [15:0] aux_word
);

  // ************************************************************
  // state
  // ************************************************************
  word_unit_pkg::state_t state_r, state_nxt; // sequencer
  logic [15:0] sample_r, sample_nxt; // latched input word
  logic [15:0] frac_r, frac_nxt; // clamped filter constant
  logic [6:0] n_r, n_nxt; // latched count
  logic [4:0] idx_r, idx_nxt; // hex source index
  logic [15:0] hold_r, hold_nxt; // hex source word
  logic [5:0] ptr_r, ptr_nxt; // circular table pointer
  logic [6:0] fill_r, fill_nxt; // samples gathered
  logic [21:0] sum_r, sum_nxt; // running table sum
  logic [6:0] last_n_r, last_n_nxt; // count of last average
  logic [15:0] y_prev_r, y_prev_nxt; // previous filter output
  logic [15:0] resid_r, resid_nxt; // filter fractional residue
  logic [15:0] dest_word_r, dest_word_nxt; // result word
  logic [15:0] aux_word_r, aux_word_nxt; // word after result
  logic dest_valid_r, dest_valid_nxt; // result strobe
  logic [5:0] dest_index_r, dest_index_nxt; // result offset
  logic done_r, done_nxt; // command finished
  logic rung_out_r, rung_out_nxt; // rung output level

  // ************************************************************
  // datapath helpers
  // ************************************************************
  logic mem_wr; // table write enable
  logic [15:0] mem_rd; // oldest sample
  logic [21:0] avg_sum; // sum after this scan
  logic [21:0] avg_quo; // average
  logic [31:0] filt_num; // filter numerator
  logic [31:0] filt_quo; // filter output
  logic [31:0] filt_rem; // filter residue
  logic n_ok; // count inside its range

  // history table
  history_mem #(
    .WIDTH(16),
    .DEPTH(HIST_DEPTH),
    .AW(6)
  ) u_hist (
    .clock(clock),
    .wr_en(mem_wr),
    .wr_addr(ptr_r),
    .wr_data(sample_r),
    .rd_addr(ptr_r),
    .rd_data(mem_rd)
  );

  // digit to ascii character
  function automatic logic [7:0] ascii_of(input logic [3:0] v);
    if (v < `HEX_DIGIT_TEN) begin
      return `ASCII_DIGIT_BASE + {4'h0, v};
    end else begin
      return `ASCII_ALPHA_BASE + {4'h0, v - `HEX_DIGIT_TEN};
    end
  endfunction

  // average and filter arithmetic
  always_comb begin
    avg_sum = sum_r + {6'h00, sample_r};
    if (fill_r >= n_r) begin
      avg_sum = avg_sum - {6'h00, mem_rd};
    end
    // partial fill still divides by n
    avg_quo = avg_sum / {15'h0000, n_r};
    filt_num = (`FRAC_SCALE - {16'h0000, frac_r}) * {16'h0000, sample_r}
             + {16'h0000, frac_r} * {16'h0000, y_prev_r}
             + {16'h0000, resid_r};
    filt_quo = filt_num / `FRAC_SCALE;
    filt_rem = filt_num % `FRAC_SCALE;
  end

  // count range check per operation
  always_comb begin
    case (op_sel)
      word_unit_pkg::moving_average_op: begin
        n_ok = (count_n != `COUNT_RST) && (count_n <= `AVG_N_MAX);
      end
      word_unit_pkg::hex_to_ascii_op: begin
        n_ok = (count_n != `COUNT_RST) && (count_n <= `HEX_N_MAX);
      end
      default: begin
        n_ok = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // sequencer next values
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    sample_nxt = sample_r;
    frac_nxt = frac_r;
    n_nxt = n_r;
    idx_nxt = idx_r;
    hold_nxt = hold_r;
    ptr_nxt = ptr_r;
    fill_nxt = fill_r;
    sum_nxt = sum_r;
    last_n_nxt = last_n_r;
    y_prev_nxt = y_prev_r;
    resid_nxt = resid_r;
    dest_word_nxt = dest_word_r;
    aux_word_nxt = aux_word_r;
    dest_valid_nxt = 1'b0;
    dest_index_nxt = dest_index_r;
    done_nxt = 1'b0;
    rung_out_nxt = rung_out_r;
    mem_wr = 1'b0;
    case (state_r)
      word_unit_pkg::st_idle: begin
        if (start) begin
          sample_nxt = src_a;
          n_nxt = count_n;
          if (!rung_in || !n_ok) begin
            // skipped: rung output low, nothing written
            done_nxt = 1'b1;
            rung_out_nxt = 1'b0;
          end else begin
            case (op_sel)
              word_unit_pkg::or_op: begin
                dest_word_nxt = src_a | src_b;
                dest_index_nxt = 6'h00;
                dest_valid_nxt = 1'b1;
                done_nxt = 1'b1;
                rung_out_nxt = 1'b1;
              end
              word_unit_pkg::xor_op: begin
                dest_word_nxt = src_a ^ src_b;
                dest_index_nxt = 6'h00;
                dest_valid_nxt = 1'b1;
                done_nxt = 1'b1;
                rung_out_nxt = 1'b1;
              end
              word_unit_pkg::moving_average_op: begin
                // a new window length restarts the history
                if (count_n != last_n_r) begin
                  ptr_nxt = `PTR_RST;
                  fill_nxt = `COUNT_RST;
                  sum_nxt = `SUM_RST;
                end
                last_n_nxt = count_n;
                state_nxt = word_unit_pkg::st_avg;
              end
              word_unit_pkg::recursive_filter_op: begin
                // negative or oversize constants are pinned
                if (src_b[15]) begin
                  frac_nxt = `WORD_RST;
                end else if (src_b > `FRAC_LIMIT) begin
                  frac_nxt = `FRAC_LIMIT;
                end else begin
                  frac_nxt = src_b;
                end
                state_nxt = word_unit_pkg::st_filter;
              end
              word_unit_pkg::hex_to_ascii_op: begin
                idx_nxt = 5'h00;
                state_nxt = word_unit_pkg::st_hex_lo;
              end
              default: begin
                done_nxt = 1'b1;
                rung_out_nxt = 1'b0;
              end
            endcase
          end
        end
      end
      word_unit_pkg::st_avg: begin
        // newest sample overwrites the oldest slot
        mem_wr = 1'b1;
        sum_nxt = avg_sum;
        if ({1'b0, ptr_r} == n_r - 7'h01) begin
          ptr_nxt = `PTR_RST;
        end else begin
          ptr_nxt = ptr_r + 6'h01;
        end
        if (fill_r < n_r) begin
          fill_nxt = fill_r + 7'h01;
        end
        dest_word_nxt = avg_quo[15:0];
        aux_word_nxt = {10'h000, ptr_nxt};
        dest_index_nxt = 6'h00;
        dest_valid_nxt = 1'b1;
        done_nxt = 1'b1;
        rung_out_nxt = 1'b1;
        state_nxt = word_unit_pkg::st_idle;
      end
      word_unit_pkg::st_filter: begin
        y_prev_nxt = filt_quo[15:0];
        resid_nxt = filt_rem[15:0];
        dest_word_nxt = filt_quo[15:0];
        aux_word_nxt = filt_rem[15:0];
        dest_index_nxt = 6'h00;
        dest_valid_nxt = 1'b1;
        done_nxt = 1'b1;
        rung_out_nxt = 1'b1;
        state_nxt = word_unit_pkg::st_idle;
      end
      word_unit_pkg::st_hex_lo: begin
        // top two nibbles: first in low byte
        hold_nxt = src_a;
        dest_word_nxt = {ascii_of(src_a[11:8]), ascii_of(src_a[15:12])};
        dest_index_nxt = {idx_r, 1'b0};
        dest_valid_nxt = 1'b1;
        state_nxt = word_unit_pkg::st_hex_hi;
      end
      word_unit_pkg::st_hex_hi: begin
        // low two nibbles fill the second word
        dest_word_nxt = {ascii_of(hold_r[3:0]), ascii_of(hold_r[7:4])};
        dest_index_nxt = {idx_r, 1'b1};
        dest_valid_nxt = 1'b1;
        if ({2'b00, idx_r} == n_r - 7'h01) begin
          done_nxt = 1'b1;
          rung_out_nxt = 1'b1;
          state_nxt = word_unit_pkg::st_idle;
        end else begin
          idx_nxt = idx_r + 5'h01;
          state_nxt = word_unit_pkg::st_hex_lo;
        end
      end
      default: begin
        state_nxt = word_unit_pkg::st_idle;
      end
    endcase
  end

  // ************************************************************
  // sequencer registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= word_unit_pkg::st_idle;
      sample_r <= `WORD_RST;
      frac_r <= `WORD_RST;
      n_r <= `COUNT_RST;
      idx_r <= 5'h00;
      hold_r <= `WORD_RST;
      ptr_r <= `PTR_RST;
      fill_r <= `COUNT_RST;
      sum_r <= `SUM_RST;
      last_n_r <= `COUNT_RST;
      y_prev_r <= `WORD_RST;
      resid_r <= `WORD_RST;
      dest_word_r <= `WORD_RST;
      aux_word_r <= `WORD_RST;
      dest_valid_r <= 1'b0;
      dest_index_r <= 6'h00;
      done_r <= 1'b0;
      rung_out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sample_r <= sample_nxt;
      frac_r <= frac_nxt;
      n_r <= n_nxt;
      idx_r <= idx_nxt;
      hold_r <= hold_nxt;
      ptr_r <= ptr_nxt;
      fill_r <= fill_nxt;
      sum_r <= sum_nxt;
      last_n_r <= last_n_nxt;
      y_prev_r <= y_prev_nxt;
      resid_r <= resid_nxt;
      dest_word_r <= dest_word_nxt;
      aux_word_r <= aux_word_nxt;
      dest_valid_r <= dest_valid_nxt;
      dest_index_r <= dest_index_nxt;
      done_r <= done_nxt;
      rung_out_r <= rung_out_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign busy = (state_r != word_unit_pkg::st_idle);
  assign src_index = idx_r;
  assign done = done_r;
  assign rung_out = rung_out_r;
  assign dest_valid = dest_valid_r;
  assign dest_index = dest_index_r;
  assign dest_word = dest_word_r;
  assign aux_word = aux_word_r;

endmodule

// ==== bench/word_unit_props.sv ====
`timescale 1ns/100ps

// ******
// port watcher for the word unit
// ******
module word_unit_props #(
  parameter int HIST_DEPTH = 64
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // command
  input wire logic start,
  input wire word_unit_pkg::op_t op_sel,
  input wire logic rung_in,
  input wire logic [15:0] src_a,
  input wire logic [15:0] src_b,
  input wire logic [6:0] count_n,
  // results
  input wire logic [4:0] src_index,
  input wire logic busy,
  input wire logic done,
  input wire logic rung_out,
  input wire logic dest_valid,
  input wire logic [5:0] dest_index,
  input wire logic [15:0] dest_word,
  input wire logic [15:0] aux_word
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // command taken with rung high
  logic go;
  assign go = start && !busy && rung_in;
  // legal digit or letter code
  function automatic logic is_dig(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction
  a_or_result: assert property (
    go && op_sel == word_unit_pkg::or_op |=> dest_valid && done && rung_out && dest_index == 6'h00
      && dest_word == ($past(src_a) | $past(src_b))) else $error("or result wrong");
  a_xor_result: assert property (
    go && op_sel == word_unit_pkg::xor_op |=> dest_valid && done && rung_out
      && dest_word == ($past(src_a) ^ $past(src_b))) else $error("xor result wrong");
  a_rung_skip: assert property (
    start && !busy && !rung_in |=> done && !rung_out && !dest_valid) else $error("skip not clean");
  a_rung_hold: assert property (
    !done && !$past(reset) |-> $stable(rung_out)) else $error("rung moved off done");
  a_avg_latency: assert property (
    go && op_sel == word_unit_pkg::moving_average_op && count_n inside {[7'h01:7'h40]}
      |=> busy ##1 (done && dest_valid && rung_out)) else $error("average late");
  a_filt_latency: assert property (
    go && op_sel == word_unit_pkg::recursive_filter_op |=> busy ##1 (done && dest_valid && rung_out))
    else $error("filter late");
  a_hex_chars: assert property (
    dest_valid && dest_index != 6'h00 |-> is_dig(dest_word[7:0]) && is_dig(dest_word[15:8]))
    else $error("bad digit code");
  a_hex_order: assert property (
    dest_valid && dest_index != 6'h00 |-> $past(dest_valid) && dest_index == $past(dest_index) + 6'h01)
    else $error("hex words out of order");
  a_busy_bound: assert property (
    $rose(busy) |-> ##[1:70] !busy) else $error("busy stuck");
endmodule

bind word_logic_filter_hexascii_unit word_unit_props #(.HIST_DEPTH(HIST_DEPTH)) u_props (
  .clock(clock), .reset(reset), .start(start), .op_sel(op_sel), .rung_in(rung_in),
  .src_a(src_a), .src_b(src_b), .count_n(count_n), .src_index(src_index), .busy(busy),
  .done(done), .rung_out(rung_out), .dest_valid(dest_valid), .dest_index(dest_index),
  .dest_word(dest_word), .aux_word(aux_word));

// ==== bench/test_word_logic_filter_hexascii_unit.sv ====
`timescale 1ns/100ps
`include "word_unit_regs.svh"

module test_word_logic_filter_hexascii_unit;
  // ******
  // stimulus and results
  // ******
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  word_unit_pkg::op_t op_sel = word_unit_pkg::or_op;
  logic rung_in = 1'b0;
  logic [15:0] a_r = 16'h0000;
  logic [15:0] src_b = 16'h0000;
  logic [6:0] count_n = 7'h00;
  logic hex_on = 1'b0;
  logic [15:0] hw [0:31];
  logic [15:0] src_a;
  logic [4:0] src_index;
  logic busy, done, rung_out, dest_valid;
  logic [5:0] dest_index;
  logic [15:0] dest_word, aux_word;
  logic [15:0] got [0:63];
  logic [15:0] got_aux;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 32'ha39b;

  always #4 clock = ~clock;
  // hex source follows the word the unit asks for
  assign src_a = hex_on ? hw[src_index] : a_r;

  word_logic_filter_hexascii_unit uut (
    .clock(clock), .reset(reset), .start(start), .op_sel(op_sel), .rung_in(rung_in),
    .src_a(src_a), .src_b(src_b), .count_n(count_n), .src_index(src_index), .busy(busy),
    .done(done), .rung_out(rung_out), .dest_valid(dest_valid), .dest_index(dest_index),
    .dest_word(dest_word), .aux_word(aux_word));

  // ******
  // compare, expectation and command tasks
  // ******
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask

  // digit code, letters start at 41h
  function automatic logic [7:0] asc(input logic [3:0] d);
    return (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
  endfunction

  // one command, collect every result word until done
  task automatic run(input word_unit_pkg::op_t op, input logic r, input logic [15:0] a,
                     input logic [15:0] b, input logic [6:0] n, input int nexp);
    int k;
    int nv;
    bit fin;
    k = 0;
    nv = 0;
    fin = 1'b0;
    foreach (got[m]) got[m] = 16'hxxxx;
    @(posedge clock);
    start <= 1'b1;
    op_sel <= op;
    rung_in <= r;
    a_r <= a;
    src_b <= b;
    count_n <= n;
    hex_on <= (op == word_unit_pkg::hex_to_ascii_op);
    @(posedge clock);
    start <= 1'b0;
    while (k < 80 && !fin) begin
      @(negedge clock);
      k++;
      if (dest_valid === 1'b1) begin
        got[dest_index] = dest_word;
        got_aux = aux_word;
        nv++;
      end
      fin = (done === 1'b1);
    end
    if (!fin) miscompares++;
    chk16(nv[15:0], nexp[15:0]);
    chk1(rung_out, nexp != 0);
  endtask

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ******
  // main sequence
  // ******
  initial begin
    int i, j, nn, x, fc;
    int unsigned acc, y, res;
    logic [15:0] q [$];
    logic [15:0] av [0:7];
    av = '{16'h03E8, 16'h03ED, 16'h03F1, 16'h03F4, 16'h03EF, 16'h03EC, 16'h03E6, 16'h03E2};
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    // logic ops, known pair then random with rung
    run(word_unit_pkg::or_op, 1'b1, 16'h5678, 16'h4321, 7'h00, 1);
    chk16(got[0], 16'h5779);
    run(word_unit_pkg::xor_op, 1'b1, 16'h5678, 16'h4321, 7'h00, 1);
    chk16(got[0], 16'h1559);
    for (i = 0; i < 24; i++) begin
      x = $random(seed);
      fc = $random(seed);
      j = $random(seed);
      run(j[0] ? word_unit_pkg::xor_op : word_unit_pkg::or_op, j[1], x[15:0], fc[15:0], 7'h00, j[1]);
      if (j[1]) chk16(got[0], j[0] ? x[15:0] ^ fc[15:0] : x[15:0] | fc[15:0]);
    end
    // average over five, skipped scan in the middle
    for (i = 0; i < 8; i++) begin
      run(word_unit_pkg::moving_average_op, 1'b1, av[i], 16'h0000, 7'h05, 1);
      q.push_back(av[i]);
      if (q.size() > 5) void'(q.pop_front());
      acc = q.sum() with (int'(item));
      chk16(got[0], acc[15:0] / 16'h0005);
      chk16(got_aux, 16'((i + 1) % 5));
      if (i == 3) run(word_unit_pkg::moving_average_op, 1'b0, 16'hFFFF, 16'h0000, 7'h05, 0);
    end
    // count out of range, then both ends of the range
    run(word_unit_pkg::moving_average_op, 1'b1, 16'h1234, 16'h0000, 7'h41, 0);
    run(word_unit_pkg::moving_average_op, 1'b1, 16'h1234, 16'h0000, 7'h00, 0);
    run(word_unit_pkg::moving_average_op, 1'b1, 16'hFFC0, 16'h0000, 7'h40, 1);
    chk16(got[0], 16'h03FF);
    chk16(got_aux, 16'h0001);
    run(word_unit_pkg::moving_average_op, 1'b1, 16'hBEEF, 16'h0000, 7'h01, 1);
    chk16(got[0], 16'hBEEF);
    // filter with clamp corners and a skipped scan
    y = 0;
    res = 0;
    for (i = 0; i < 16; i++) begin
      x = $random(seed);
      fc = (i % 4 == 0) ? 32'h0000_2710 : (i % 4 == 1) ? 32'h0000_270F : (i % 4 == 2) ? 32'h0000_8000 : $random(seed);
      run(word_unit_pkg::recursive_filter_op, i != 7, x[15:0], fc[15:0], 7'h00, i != 7);
      if (i != 7) begin
        fc = fc[15] ? 0 : (fc[15:0] > `FRAC_LIMIT) ? `FRAC_LIMIT : fc[15:0];
        acc = (`FRAC_SCALE - fc) * x[15:0] + fc * y + res;
        y = acc / `FRAC_SCALE;
        res = acc % `FRAC_SCALE;
        chk16(got[0], y[15:0]);
        chk16(got_aux, res[15:0]);
      end
    end
    // reset in mid-run clears previous output and residue
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    run(word_unit_pkg::recursive_filter_op, 1'b1, 16'h1235, 16'h1388, 7'h00, 1);
    chk16(got[0], 16'h091A);
    chk16(got_aux, 16'h1388);
    // hex to ascii, all digits plus random words
    foreach (hw[k]) hw[k] = 16'($random(seed));
    hw[0] = 16'h0123;
    hw[1] = 16'h4567;
    hw[2] = 16'h89AB;
    hw[3] = 16'hCDEF;
    for (i = 0; i < 5; i++) begin
      nn = (i == 0) ? 32 : (i == 1) ? 33 : (i == 2) ? 0 : ($random(seed) & 31) + 1;
      run(word_unit_pkg::hex_to_ascii_op, 1'b1, 16'h0000, 16'h0000, nn[6:0], (nn > 0 && nn < 33) ? 2 * nn : 0);
      for (j = 0; j < nn && nn < 33; j++) begin
        chk16(got[2 * j], {asc(hw[j][11:8]), asc(hw[j][15:12])});
        chk16(got[2 * j + 1], {asc(hw[j][3:0]), asc(hw[j][7:4])});
      end
    end
    close_out();
  end

  // hang guard
  initial begin
    #(8 * 5000);
    miscompares++;
    close_out();
  end
endmodule
